// [design/ltp_ctrl.sv]
`timescale 1ns/1ps
`include "ltp_defines.svh"
module ltp_ctrl #(
  parameter logic [`LTP_CW-1:0] DST_CYC = `LTP_CW'(`LTP_DST_CYC),
  parameter logic [`LTP_CW-1:0] WAKE_CYC = `LTP_CW'(`LTP_BUS_FILT_CYC),
  parameter logic [`LTP_CW-1:0] LW_CYC = `LTP_CW'(`LTP_LWAKE_CYC)
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // host logic pins
  input wire logic txd_i,
  input wire logic en_i,
  output logic rxd_o,
  output logic wake_src_o,
  // bus pin, open drain
  input wire logic bus_i,
  output logic bus_o,
  output logic bus_oe_n_o,
  // monitors and local wake
  input wire logic overtemp_i,
  input wire logic undervolt_i,
  input wire logic local_wake_n_i,
  // power control
  output logic inh_o,
  output logic term_o,
  output logic por_o,
  // received edge stream
  output logic rx_valid_o,
  output logic [`LTP_FIFO_W-1:0] rx_data_o,
  input wire logic rx_ready_i,
  output logic rx_room_o
);

  // ****************************************
  // state
  // ****************************************
  ltp_pkg::ltp_state_s q_ff;
  ltp_pkg::ltp_state_s nxt_q;
  logic txd_s;
  logic en_s;
  logic bus_s;
  logic lwn_s;
  logic ot_s;
  logic uv_s;
  logic txd_fell;
  logic txd_rose;
  logic rx_push;
  logic fifo_in_ready;

  assign txd_s = q_ff.s2[`LTP_IX_TXD];
  assign en_s = q_ff.s2[`LTP_IX_EN];
  assign bus_s = q_ff.s2[`LTP_IX_BUS];
  assign lwn_s = q_ff.s2[`LTP_IX_LWN];
  assign ot_s = q_ff.s2[`LTP_IX_OT];
  assign uv_s = q_ff.s2[`LTP_IX_UV];
  assign txd_fell = q_ff.txd_prev & ~txd_s;
  assign txd_rose = ~q_ff.txd_prev & txd_s;
  // only edges are queued; level changes made while the fifo is full merge, so a pair of them is lost
  assign rx_push = (q_ff.mode == ltp_pkg::LTP_NORMAL) & (bus_s != q_ff.bus_prev);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = {undervolt_i, overtemp_i, local_wake_n_i, bus_i, en_i, txd_i};
    nxt_q.s2 = q_ff.s1;
    nxt_q.txd_prev = txd_s;

    case (q_ff.mode)
      ltp_pkg::LTP_POR: begin
        // reset synchroniser values would flash a false standby wake request
        if (q_ff.wake_cnt != `LTP_CW'(`LTP_POR_SETTLE)) begin
          nxt_q.wake_cnt = q_ff.wake_cnt + `LTP_CW'(1);
        end else if (en_s) begin
          nxt_q.mode = ltp_pkg::LTP_NORMAL;
        end else begin
          nxt_q.mode = ltp_pkg::LTP_STANDBY;
        end
      end
      ltp_pkg::LTP_NORMAL: begin
        // R13 enable low sleeps
        if (~en_s) begin
          nxt_q.mode = ltp_pkg::LTP_SLEEP;
          // R10 sample bus on entry
          nxt_q.lock = ~bus_s;
          nxt_q.wake_cnt = '0;
          nxt_q.wake_dom = 1'b0;
          nxt_q.lw_cnt = '0;
        end
      end
      ltp_pkg::LTP_STANDBY: begin
        if (en_s) begin
          nxt_q.mode = ltp_pkg::LTP_NORMAL;
        end
      end
      ltp_pkg::LTP_SLEEP: begin
        if (en_s) begin
          nxt_q.mode = ltp_pkg::LTP_NORMAL;
        end else begin
          if (~lwn_s) begin
            if (q_ff.lw_cnt == LW_CYC - `LTP_CW'(1)) begin
              nxt_q.mode = ltp_pkg::LTP_STANDBY;
              nxt_q.wake_src = 1'b0;
            end else begin
              nxt_q.lw_cnt = q_ff.lw_cnt + `LTP_CW'(1);
            end
          end else begin
            nxt_q.lw_cnt = '0;
          end
          // R11 stuck bus lockout
          if (q_ff.lock) begin
            if (bus_s) begin
              nxt_q.lock = 1'b0;
            end
          end else if (~bus_s) begin
            // R14 dominant filter
            if (~q_ff.wake_dom) begin
              if (q_ff.wake_cnt == WAKE_CYC - `LTP_CW'(1)) begin
                nxt_q.wake_dom = 1'b1;
              end else begin
                nxt_q.wake_cnt = q_ff.wake_cnt + `LTP_CW'(1);
              end
            end
          end else begin
            // R14 return to recessive
            if (q_ff.wake_dom && (nxt_q.mode == ltp_pkg::LTP_SLEEP)) begin
              nxt_q.mode = ltp_pkg::LTP_STANDBY;
              nxt_q.wake_src = 1'b1;
            end
            nxt_q.wake_cnt = '0;
            nxt_q.wake_dom = 1'b0;
          end
        end
      end
      default: begin
        nxt_q.mode = ltp_pkg::LTP_POR;
      end
    endcase

    // R12 undervoltage holds reset
    if (uv_s) begin
      nxt_q.mode = ltp_pkg::LTP_POR;
      nxt_q.wake_cnt = '0;
    end
    if (nxt_q.mode != ltp_pkg::LTP_SLEEP) begin
      nxt_q.lock = 1'b0;
      nxt_q.wake_dom = 1'b0;
      nxt_q.lw_cnt = '0;
    end
    if ((nxt_q.mode != ltp_pkg::LTP_SLEEP) && (nxt_q.mode != ltp_pkg::LTP_POR)) begin
      nxt_q.wake_cnt = '0;
    end

    // dominant timeout, only meaningful in normal mode
    if (nxt_q.mode != ltp_pkg::LTP_NORMAL) begin
      nxt_q.dst_run = 1'b0;
      nxt_q.dst_fault = 1'b0;
      nxt_q.dst_cnt = '0;
    end else if (txd_rose) begin
      // R3 rising edge clears
      nxt_q.dst_run = 1'b0;
      nxt_q.dst_fault = 1'b0;
      nxt_q.dst_cnt = '0;
    end else if (txd_fell) begin
      // R1 falling edge starts
      nxt_q.dst_run = 1'b1;
      nxt_q.dst_cnt = '0;
    end else if (q_ff.dst_run && ~q_ff.dst_fault) begin
      // R15 counter on clock
      if (q_ff.dst_cnt == DST_CYC - `LTP_CW'(1)) begin
        nxt_q.dst_fault = 1'b1;
      end else begin
        nxt_q.dst_cnt = q_ff.dst_cnt + `LTP_CW'(1);
      end
    end

    // R2 R8 R9 driver gating
    nxt_q.drv_n = ~((nxt_q.mode == ltp_pkg::LTP_NORMAL) & ~txd_s & ~nxt_q.dst_fault & ~ot_s);
    // R4 outputs held in fault
    case (nxt_q.mode)
      ltp_pkg::LTP_NORMAL: nxt_q.rxd = bus_s;
      ltp_pkg::LTP_STANDBY: nxt_q.rxd = 1'b0;
      default: nxt_q.rxd = 1'b1;
    endcase
    nxt_q.regulator_inhibit_output = (nxt_q.mode == ltp_pkg::LTP_NORMAL) | (nxt_q.mode == ltp_pkg::LTP_STANDBY);
    nxt_q.term = nxt_q.regulator_inhibit_output;
    nxt_q.por = (nxt_q.mode == ltp_pkg::LTP_POR);

    // a full fifo holds the edge back until it is taken
    if (q_ff.mode != ltp_pkg::LTP_NORMAL) begin
      nxt_q.bus_prev = bus_s;
    end else if (rx_push && fifo_in_ready) begin
      nxt_q.bus_prev = bus_s;
    end
    nxt_q.rx_room = fifo_in_ready;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q_ff <= '0;
      // R5 open transmit reads low
      q_ff.s1 <= `LTP_SYNC_RST;
      q_ff.s2 <= `LTP_SYNC_RST;
      q_ff.bus_prev <= 1'b1;
      q_ff.mode <= ltp_pkg::LTP_POR;
      q_ff.drv_n <= 1'b1;
      q_ff.rxd <= 1'b1;
      q_ff.por <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // receive queue
  // ****************************************
  ltp_fifo #(
    .W(`LTP_FIFO_W),
    .D(`LTP_FIFO_D)
  ) u_rx_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .in_valid_i(rx_push),
    .in_data_i(bus_s),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  assign bus_o = 1'b0;
  assign bus_oe_n_o = q_ff.drv_n;
  assign rxd_o = q_ff.rxd;
  assign wake_src_o = q_ff.wake_src;
  assign inh_o = q_ff.regulator_inhibit_output;
  assign term_o = q_ff.term;
  assign por_o = q_ff.por;
  assign rx_room_o = q_ff.rx_room;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  dst_start_a: assert property ( // R1
    q_ff.mode == ltp_pkg::LTP_NORMAL && txd_fell && en_s && !uv_s
    |=> q_ff.dst_run && q_ff.dst_cnt == '0) else $error("timer not started");
  dst_drv_off_a: assert property ( // R2
    q_ff.dst_fault |-> q_ff.drv_n) else $error("driver on in timeout");
  dst_clear_a: assert property ( // R3
    q_ff.mode == ltp_pkg::LTP_NORMAL && txd_rose
    |=> !q_ff.dst_fault && q_ff.dst_cnt == '0) else $error("timeout not cleared");
  dst_hold_a: assert property ( // R4
    q_ff.dst_fault |-> q_ff.regulator_inhibit_output && q_ff.term && q_ff.rxd == $past(bus_s))
    else $error("outputs changed in timeout");
  dst_len_a: assert property ( // R15
    $rose(q_ff.dst_fault) |-> $past(q_ff.dst_cnt) == DST_CYC - `LTP_CW'(1))
    else $error("timeout length wrong");
  ot_drv_off_a: assert property ( // R8
    ot_s |=> q_ff.drv_n) else $error("driver on in overtemp");
  ot_resume_a: assert property ( // R9
    !q_ff.drv_n |-> q_ff.mode == ltp_pkg::LTP_NORMAL && !$past(ot_s))
    else $error("driver on outside normal");
  uv_hold_a: assert property ( // R12
    uv_s |=> q_ff.mode == ltp_pkg::LTP_POR && q_ff.drv_n && q_ff.por)
    else $error("undervoltage not held");
  sleep_sample_a: assert property ( // R10
    $rose(q_ff.mode == ltp_pkg::LTP_SLEEP) |-> q_ff.lock == !$past(bus_s))
    else $error("bus not sampled at sleep");
  lock_block_a: assert property ( // R11
    q_ff.lock |-> q_ff.wake_cnt == '0 && !q_ff.wake_dom) else $error("wake armed under lock");
  en_sleep_a: assert property ( // R13
    q_ff.mode == ltp_pkg::LTP_NORMAL && !en_s && !uv_s
    |=> q_ff.mode == ltp_pkg::LTP_SLEEP) else $error("enable low did not sleep");
  remote_wake_a: assert property ( // R14
    q_ff.mode == ltp_pkg::LTP_STANDBY && $past(q_ff.mode) == ltp_pkg::LTP_SLEEP
    && q_ff.wake_src |-> $past(q_ff.wake_dom && bus_s)) else $error("remote wake too early");

  cov_timeout_c: cover property ($rose(q_ff.dst_fault));
  cov_lock_clear_c: cover property (q_ff.lock ##1 !q_ff.lock && q_ff.mode == ltp_pkg::LTP_SLEEP);
  cov_remote_c: cover property ($rose(q_ff.mode == ltp_pkg::LTP_STANDBY) && q_ff.wake_src);
  cov_rx_full_c: cover property (!fifo_in_ready && rx_push);
endmodule // ltp_ctrl

// [design/ltp_fifo.sv]
`timescale 1ns/1ps
`include "ltp_defines.svh"
module ltp_fifo #(
  parameter int W = `LTP_FIFO_W,
  parameter int D = `LTP_FIFO_D
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ltp_fifo_s;

  ltp_fifo_s q_ff;
  ltp_fifo_s nxt_q;
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (q_ff.cnt != (AW+1)'(D));
  assign out_valid_o = (q_ff.cnt != '0);
  assign out_data_o = q_ff.mem[q_ff.rd];

  always_comb begin
    nxt_q = q_ff;
    do_wr = in_valid_i & in_ready_o;
    do_rd = out_valid_o & out_ready_i;
    if (do_wr) begin
      nxt_q.mem[q_ff.wr] = in_data_i;
      nxt_q.wr = (q_ff.wr == AW'(D-1)) ? '0 : q_ff.wr + AW'(1);
    end
    if (do_rd) begin
      nxt_q.rd = (q_ff.rd == AW'(D-1)) ? '0 : q_ff.rd + AW'(1);
    end
    if (do_wr & ~do_rd) begin
      nxt_q.cnt = q_ff.cnt + (AW+1)'(1);
    end else if (do_rd & ~do_wr) begin
      nxt_q.cnt = q_ff.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  fifo_bound_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q_ff.cnt <= (AW+1)'(D)) else $error("fifo count past depth");
endmodule // ltp_fifo

// [shared/ltp_defines.svh]
// Operation
// R1: in normal mode a transmit falling edge starts the dominant timeout timer
// R2: transmit low past the dominant timeout switches the bus driver off; a low held from before normal mode is never timed out
// R3: transmit rising edge clears the fault, resets the timer, re-enables driver
// R4: during timeout fault stay normal; receive follows bus; inhibit, termination stay on
// R5: an open transmit input reads as low, a known state
// R6: master picks bit rate so a 13 to 26 bit break beats timeout
// R7: slave picks bit rate so nine dominant bits plus margin beat timeout
// R8: over-temperature indication disables the bus driver
// R9: driver returns after over-temperature only in normal mode; outputs unchanged meanwhile
// R10: every sleep entry samples the bus for a stuck dominant level
// R11: bus dominant at sleep entry blocks remote wake until recessive is seen
// R12: supply undervoltage holds power-on reset and keeps the bus quiet
// R13: mode enable high gives normal mode; low gives sleep without transmit path
// R14: remote wake needs falling edge, dominant for filter time, then recessive
// R15: dominant timeout is a counter on the clock with a parameter length
`ifndef LTP_DEFINES_SVH
`define LTP_DEFINES_SVH

// ****************************************
// time base
// ****************************************
`define LTP_CLK_MHZ 250
// minimum times; each rounds up exactly at an integer clock rate
`define LTP_DST_US 1000
`define LTP_DST_CYC (`LTP_DST_US * `LTP_CLK_MHZ)
`define LTP_BUS_FILT_US 30
`define LTP_BUS_FILT_CYC (`LTP_BUS_FILT_US * `LTP_CLK_MHZ)
`define LTP_LWAKE_US 30
`define LTP_LWAKE_CYC (`LTP_LWAKE_US * `LTP_CLK_MHZ)
`define LTP_CW 20
// synchroniser depth before the first mode decision out of power-on reset
`define LTP_POR_SETTLE 2

// ****************************************
// synchroniser bit positions
// ****************************************
`define LTP_NSYNC 6
`define LTP_IX_TXD 0
`define LTP_IX_EN 1
`define LTP_IX_BUS 2
`define LTP_IX_LWN 3
`define LTP_IX_OT 4
`define LTP_IX_UV 5
`define LTP_SYNC_RST 6'h08

// ****************************************
// receive fifo shape
// ****************************************
`define LTP_FIFO_W 1
`define LTP_FIFO_D 16

`endif

// [shared/ltp_pkg.sv]
`include "ltp_defines.svh"

package ltp_pkg;

  typedef enum logic [1:0] {
    LTP_POR,
    LTP_SLEEP,
    LTP_STANDBY,
    LTP_NORMAL
  } ltp_mode_e;

  typedef struct packed {
    logic [`LTP_NSYNC-1:0] s1;
    logic [`LTP_NSYNC-1:0] s2;
    logic txd_prev;
    logic bus_prev;
    ltp_mode_e mode;
    logic dst_run;
    logic dst_fault;
    logic [`LTP_CW-1:0] dst_cnt;
    logic lock;
    logic wake_dom;
    logic [`LTP_CW-1:0] wake_cnt;
    logic [`LTP_CW-1:0] lw_cnt;
    logic wake_src;
    logic drv_n;
    logic rxd;
    logic regulator_inhibit_output;
    logic term;
    logic por;
    logic rx_room;
  } ltp_state_s;

endpackage

// [verif/lin_transceiver_protection_ctrl_test.sv]
`timescale 1ns/1ps
`include "ltp_defines.svh"
module lin_transceiver_protection_ctrl_test;
  // short counts keep the run brief
  localparam logic [19:0] DST = 20'h40;
  localparam logic [19:0] WK = 20'h8;
  logic mclk_i = 1'b0;
  logic srst_i;
  logic en_i, ot, uv, lw_n, dom;
  logic send, hold, stall;
  logic scoring = 1'b0;
  logic txd_i, bus_w, busy, rx_ready_i;
  logic rxd_o, wake_src_o, bus_o, bus_oe_n_o, inh_o, term_o, por_o, rx_valid_o, rx_room_o;
  logic [`LTP_FIFO_W-1:0] rx_data_o;
  logic [7:0] byte_v;
  logic [7:0] expq[$];
  int miscompares = 0, comparisons = 0, seed = 80854, cycles = 0, n;

  always #2 mclk_i = ~mclk_i;
  // open drain wire with pull-up; dom is a foreign node
  assign bus_w = ((!bus_oe_n_o && !bus_o) || dom) ? 1'b0 : 1'b1;

  ltp_ctrl #(.DST_CYC(DST), .WAKE_CYC(WK), .LW_CYC(WK)) ltp_ctrl_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .txd_i(txd_i), .en_i(en_i), .rxd_o(rxd_o),
    .wake_src_o(wake_src_o), .bus_i(bus_w), .bus_o(bus_o), .bus_oe_n_o(bus_oe_n_o),
    .overtemp_i(ot), .undervolt_i(uv), .local_wake_n_i(lw_n), .inh_o(inh_o),
    .term_o(term_o), .por_o(por_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_ready_i), .rx_room_o(rx_room_o));

  ltp_host_model #(.BIT_CYC(2)) ltp_host_model_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .send_i(send), .byte_i(byte_v),
    .hold_low_i(hold), .stall_i(stall), .txd_o(txd_i), .rx_ready_o(rx_ready_i),
    .busy_o(busy));

  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic half();
    @(negedge mclk_i);
  endtask

  // ****************************************
  // receive stream monitor
  // ****************************************
  always @(posedge mclk_i) begin
    cycles++;
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1 && scoring) begin
      if (expq.size() == 0) begin
        chk(8'hee, {7'h0, rx_data_o});
      end else begin
        chk({7'h0, rx_data_o}, expq.pop_front());
      end
    end
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    logic [9:0] fr;
    logic pv;
    srst_i <= 1'b1;
    en_i <= 1'b1;
    ot <= 1'b0;
    uv <= 1'b0;
    lw_n <= 1'b1;
    dom <= 1'b0;
    send <= 1'b0;
    hold <= 1'b0;
    stall <= 1'b0;
    byte_v <= 8'h00;
    tick(1);
    half();
    chk(por_o, 1'b1);
    chk(bus_oe_n_o, 1'b1);
    chk(inh_o, 1'b0);
    tick(2);
    srst_i <= 1'b0;
    tick(20);
    scoring <= 1'b1;
    half();
    chk(por_o, 1'b0);
    chk({inh_o, term_o}, 8'h3);
    // frames under random host stalls
    repeat (4) begin
      tick(1);
      fr = {1'b1, 8'($random(seed)), 1'b0};
      byte_v <= fr[8:1];
      send <= 1'b1;
      pv = 1'b1;
      for (int i = 0; i < 10; i++) begin
        if (fr[i] != pv) expq.push_back({7'h0, fr[i]});
        pv = fr[i];
      end
      tick(1);
      send <= 1'b0;
      for (n = 0; n < 100 && (busy || n < 3); n++) begin
        stall <= 1'($random(seed));
        tick(1);
      end
      stall <= 1'b0;
      tick(12);
    end
    // longest break, 26 bits of two cycles, stays under the timeout
    expq.push_back(8'h0);
    expq.push_back(8'h1);
    hold <= 1'b1;
    tick(52);
    half();
    chk(bus_oe_n_o, 1'b0);
    tick(1);
    hold <= 1'b0;
    tick(12);
    // overtemperature while transmitting dominant
    expq.push_back(8'h0);
    expq.push_back(8'h1);
    expq.push_back(8'h0);
    expq.push_back(8'h1);
    hold <= 1'b1;
    tick(4);
    ot <= 1'b1;
    tick(5);
    half();
    chk(bus_oe_n_o, 1'b1);
    chk(inh_o, 1'b1);
    tick(1);
    ot <= 1'b0;
    tick(5);
    half();
    chk(bus_oe_n_o, 1'b0);
    tick(1);
    hold <= 1'b0;
    tick(12);
    // dominant timeout, clear, re-arm
    expq.push_back(8'h0);
    expq.push_back(8'h1);
    expq.push_back(8'h0);
    expq.push_back(8'h1);
    hold <= 1'b1;
    for (n = 0; n < 10 && bus_oe_n_o !== 1'b0; n++) half();
    for (n = 0; n < 100 && bus_oe_n_o === 1'b0; n++) half();
    chk(8'(n), 8'(DST));
    tick(4);
    half();
    chk(rxd_o, 1'b1);
    chk({inh_o, term_o, por_o}, 8'h6);
    tick(1);
    hold <= 1'b0;
    tick(5);
    hold <= 1'b1;
    tick(6);
    half();
    chk(bus_oe_n_o, 1'b0);
    tick(1);
    hold <= 1'b0;
    tick(12);
    // fifo filled by a foreign node, then drained
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      if (i < 16) expq.push_back({7'h0, dom});
      dom <= ~dom;
      tick(4);
    end
    half();
    chk(rx_room_o, 1'b0);
    tick(1);
    stall <= 1'b0;
    tick(30);
    half();
    chk(8'(expq.size()), 8'h0);
    // undervoltage holds reset, bus quiet
    tick(1);
    scoring <= 1'b0;
    hold <= 1'b1;
    tick(6);
    uv <= 1'b1;
    tick(6);
    half();
    chk({por_o, bus_oe_n_o, inh_o}, 8'h6);
    tick(1);
    uv <= 1'b0;
    hold <= 1'b0;
    tick(6);
    half();
    chk({por_o, inh_o}, 8'h1);
    // sleep entered with bus stuck dominant
    tick(1);
    dom <= 1'b1;
    tick(4);
    en_i <= 1'b0;
    tick(6);
    hold <= 1'b1;
    tick(30);
    half();
    chk({bus_oe_n_o, inh_o}, 8'h2);
    tick(1);
    dom <= 1'b0;
    tick(12);
    half();
    chk({inh_o, rxd_o}, 8'h1);
    tick(1);
    dom <= 1'b1;
    tick(16);
    dom <= 1'b0;
    tick(8);
    half();
    chk({rxd_o, inh_o, wake_src_o}, 8'h3);
    tick(1);
    hold <= 1'b0;
    en_i <= 1'b1;
    tick(8);
    // local wake from a clean sleep
    en_i <= 1'b0;
    tick(8);
    lw_n <= 1'b0;
    tick(14);
    lw_n <= 1'b1;
    tick(6);
    half();
    chk({rxd_o, inh_o, wake_src_o}, 8'h2);
    complete_run();
  end
endmodule // lin_transceiver_protection_ctrl_test

// [verif/ltp_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// host side protocol controller
// ****************************************
module ltp_host_model #(
  parameter int BIT_CYC = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // commands from the bench
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  input wire logic hold_low_i,
  input wire logic stall_i,
  // device side
  output logic txd_o,
  output logic rx_ready_o,
  output logic busy_o
);
  logic [9:0] sh_ff = 10'h3ff;
  logic [3:0] nbit_ff = 4'h0;
  int cyc_ff = 0;
  // hold low fakes a stuck transmit line
  assign txd_o = hold_low_i ? 1'b0 : sh_ff[0];
  assign busy_o = (nbit_ff != 4'h0);
  // bit period keeps start plus data under the timeout
  always @(posedge mclk_i) begin
    rx_ready_o <= !stall_i;
    if (srst_i) begin
      sh_ff <= 10'h3ff;
      nbit_ff <= 4'h0;
    end else if (send_i && nbit_ff == 4'h0) begin
      sh_ff <= {1'b1, byte_i, 1'b0};
      nbit_ff <= 4'ha;
      cyc_ff <= 0;
    end else if (nbit_ff != 4'h0) begin
      if (cyc_ff == BIT_CYC - 1) begin
        cyc_ff <= 0;
        sh_ff <= {1'b1, sh_ff[9:1]};
        nbit_ff <= nbit_ff - 4'h1;
      end else begin
        cyc_ff <= cyc_ff + 1;
      end
    end
  end
endmodule // ltp_host_model
